/* File: dsw_defs.svh */
// Constants for the serial write port of the converter.
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH
`define DSW_WORD_BITS     24
`define DSW_DATA_BITS     16
`define DSW_MODE_HI_POS   17
`define DSW_MODE_LO_POS   16
`define DSW_DATA_MSB      15
`define DSW_MIDSCALE      16'h8000
`define DSW_MODE_RESET    2'h0
`define DSW_FIFO_DEPTH    32
`endif

/* File: dsw_pkg.sv */
// Types shared by the serial write port.
`default_nettype none
package dsw_pkg;
    typedef enum logic [1:0] {
        DSW_MODE_NORMAL,
        DSW_MODE_PD1K,
        DSW_MODE_PD100K,
        DSW_MODE_PDTRI
    } dsw_mode_type;
endpackage
`default_nettype wire

/* File: dsw_fifo.sv */
// The data FIFO of the serial write port is defined in dsw_serial_port.sv with the rest of the logic.

/* File: dsw_serial_port.sv */
// Serial write port: link-side shifter, word crossing, FIFO and converter register.
`include "dsw_defs.svh"
`default_nettype none
// ----------------------------------------------------------------
// Word buffer
// ----------------------------------------------------------------
// A plain first-in first-out store with valid and ready on both sides.
// One spare pointer bit tells a full store from an empty one.
// The fill side is refused only while all slots hold words.
module dsw_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    logic             doWr;
    logic             doRd;

    assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData  = mem[rdPtr_q[AW-1:0]];
    assign doWr     = ce && inValid && inReady;
    assign doRd     = ce && outValid && outReady;

    // Storage has no reset: a slot is read only after it was written.
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr_q <= '0;
        end else if (doWr) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdPtr_q <= '0;
        end else if (doRd) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule

// ----------------------------------------------------------------
// Serial write port
// ----------------------------------------------------------------
module dsw_serial_port #(
    parameter int FIFO_DEPTH = `DSW_FIFO_DEPTH
) (
    // System clock
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    // Serial link
    input  wire logic                       serClk,
    input  wire logic                       frameSelN,
    input  wire logic                       serData,
    // Converter outputs
    output logic [`DSW_DATA_BITS-1:0]       dacCode,
    output dsw_pkg::dsw_mode_type           powerMode,
    output logic                            wordDone,
    output logic                            fifoFull
);
    import dsw_pkg::*;

    localparam int CW = $clog2(`DSW_WORD_BITS + 1);
    localparam int FW = `DSW_DATA_BITS + 2;

    // ----------------------------------------------------------------
    // Link domain
    // ----------------------------------------------------------------
    // The serial clock stops between frames, so the abort is done
    // asynchronously by the frame select itself: its high level holds
    // the shifter and counter clear, which also covers an early release.
    logic [`DSW_WORD_BITS-1:0] shift_q;
    logic [CW-1:0]             bitCnt_q;
    logic [FW-1:0]             linkWord_q;
    logic                      linkTgl_q;

    always_ff @(negedge serClk or posedge frameSelN) begin
        if (frameSelN) begin
            shift_q  <= '0;
            bitCnt_q <= '0;
        end else if (bitCnt_q < CW'(`DSW_WORD_BITS)) begin
            shift_q  <= {shift_q[`DSW_WORD_BITS-2:0], serData};
            bitCnt_q <= bitCnt_q + 1'b1;
        end
    end

    // High on the link edge that carries the last bit of a word; edges
    // after it while select stays low are ignored until select rises.
    // The top bits above the mode field are not kept.
    logic lastBit;
    assign lastBit = !frameSelN && bitCnt_q == CW'(`DSW_WORD_BITS - 1);

    // Capture mode and data on the 24th edge.
    always_ff @(negedge serClk) begin
        if (lastBit) begin
            linkWord_q <= {shift_q[`DSW_MODE_HI_POS-1:0], serData};
        end
    end

    // The toggle is the only link flop that the system side compares, so
    // it alone is reset. Reset is released while the host holds the serial
    // clock still, so the release never meets a link edge.
    always_ff @(negedge serClk or negedge rstn) begin
        if (!rstn) begin
            linkTgl_q <= 1'b0;
        end else if (lastBit) begin
            linkTgl_q <= ~linkTgl_q;
        end
    end

    // ----------------------------------------------------------------
    // Crossing into the system clock
    // ----------------------------------------------------------------
    // The word register is stable for a whole word time after the toggle,
    // far longer than the three system cycles needed to take it.
    // While ce is low the chain stands still: a word completed then is
    // taken when ce returns, but two words completed in that time cancel
    // out and neither is taken.
    logic tglS1_q;
    logic tglS2_q;
    logic tglS3_q;
    logic newWord;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tglS1_q <= 1'b0;
            tglS2_q <= 1'b0;
            tglS3_q <= 1'b0;
        end else if (ce) begin
            tglS1_q <= linkTgl_q;
            tglS2_q <= tglS1_q;
            tglS3_q <= tglS2_q;
        end
    end

    assign newWord = tglS2_q ^ tglS3_q;

    // ----------------------------------------------------------------
    // Buffer and converter register
    // ----------------------------------------------------------------
    logic [FW-1:0] fifoOut;
    logic          fifoValid;
    logic          fifoReady;

    dsw_fifo #(
        .WIDTH    (FW),
        .DEPTH    (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .inData   (linkWord_q),
        .inValid  (newWord),
        .inReady  (fifoReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (1'b1)
    );

    // Code and mode change together, only when a whole word arrives.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dacCode   <= `DSW_MIDSCALE;
            powerMode <= dsw_mode_type'(`DSW_MODE_RESET);
        end else if (ce && fifoValid) begin
            dacCode   <= fifoOut[`DSW_DATA_MSB:0];
            powerMode <= dsw_mode_type'(fifoOut[FW-1:FW-2]);
        end
    end

    // Marks the one cycle in which the new code and mode first show.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wordDone <= 1'b0;
        end else if (ce) begin
            wordDone <= fifoValid;
        end
    end

    // The drain is always ready, so the full flag stays low in normal use.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fifoFull <= 1'b0;
        end else if (ce) begin
            fifoFull <= !fifoReady;
        end
    end
endmodule
`default_nettype wire

/* File: dsw_serial_port_chk.sv */
// Checker for the serial write port.
`include "dsw_defs.svh"
`default_nettype none
module dsw_serial_port_chk #(
    parameter int FIFO_DEPTH = 32
) (
    // System side
    input wire logic                       clk,
    input wire logic                       rstn,
    input wire logic                       ce,
    // Serial link and outputs
    input wire logic                       serClk,
    input wire logic                       frameSelN,
    input wire logic                       serData,
    input wire logic [`DSW_DATA_BITS-1:0]  dacCode,
    input wire dsw_pkg::dsw_mode_type      powerMode,
    input wire logic                       wordDone,
    input wire logic                       fifoFull
);
    import dsw_pkg::*;
    logic [4:0]  cnt = 5'h00;
    logic [23:0] sh;
    logic [23:0] expW;
    logic        tg = 1'b0;
    logic        tgP = 1'b0;
    logic [3:0]  age = 4'hF;
    // Shadow shifter; a high select clears its counter cnt, so only whole words toggle tg.
    always @(negedge serClk or posedge frameSelN) begin
        cnt <= frameSelN ? 5'h00 : cnt + 5'h01;
        sh <= {sh[22:0], serData};
        if (!frameSelN && cnt == 5'h17) begin
            expW <= {sh[22:0], serData};
            tg <= ~tg;
        end
    end
    always @(posedge clk) begin
        tgP <= tg;
        age <= (tg != tgP) ? 4'h0 : age + {3'h0, age != 4'hF};
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_reset_load: assert property (disable iff (1'b0) !rstn && ce |=>
        dacCode == `DSW_MIDSCALE && powerMode == DSW_MODE_NORMAL) else $error("bad reset value");
    a_hold_code: assert property (!wordDone |-> $stable(dacCode)) else $error("code moved");
    a_hold_mode: assert property (!wordDone |-> $stable(powerMode)) else $error("mode moved");
    a_done_pulse: assert property (wordDone |=> !wordDone) else $error("long done");
    a_done_soon: assert property (tg != tgP |-> ##[1:7] wordDone) else $error("no update");
    a_done_cause: assert property (wordDone |-> age < 4'h7) else $error("stray update");
    a_word_value: assert property (wordDone |-> dacCode == expW[15:0] &&
        powerMode == expW[`DSW_MODE_HI_POS:`DSW_MODE_LO_POS]) else $error("wrong word");
    a_no_full: assert property (!fifoFull) else $error("fifo full");
endmodule
bind dsw_serial_port dsw_serial_port_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clk(clk), .rstn(rstn), .ce(ce),
    .serClk(serClk), .frameSelN(frameSelN), .serData(serData), .dacCode(dacCode), .powerMode(powerMode),
    .wordDone(wordDone), .fifoFull(fifoFull));
`default_nettype wire

/* File: dsw_host_model.sv */
// Serial master model that sends frames to the port.
`default_nettype none
module dsw_host_model (
    // Serial link
    output var logic serClk = 1'b1,
    output var logic frameSelN = 1'b1,
    output var logic serData = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock idles high outside frames; a 34 ns period keeps under the ceiling.
    task automatic send(input logic [23:0] w, input int n);
        frameSelN = 1'b0;
        #13;
        for (int i = 23; i > 23 - n; i--) begin
            serData = w[i];
            #17 serClk = 1'b0;
            #17 serClk = 1'b1;
        end
        serData = ~serData;
        frameSelN = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

/* File: tb_dac_serial_write_port.sv */
// Testbench for the serial write port.
`include "dsw_defs.svh"
`default_nettype none
`define CHK(nm, e, a) begin nTests++; if ((a) !== (e)) begin errTotal++; $display("CHECK FAILED %s %h %h", nm, e, a); end end
module tb_dac_serial_write_port;
    timeunit 1ns;
    timeprecision 1ns;
    import dsw_pkg::*;
    typedef struct {logic [23:0] w; logic [15:0] c; dsw_mode_type m;} dsw_row_type;
    logic                      clk = 1'b0;
    logic                      rstn = 1'b0;
    logic                      serClk, frameSelN, serData, wordDone, fifoFull;
    logic [`DSW_DATA_BITS-1:0] dacCode;
    dsw_mode_type              powerMode;
    int                        errTotal = 0, nTests = 0, nDone = 0, base;
    dsw_row_type rows[5] = '{'{24'hC0ABCD, 16'hABCD, DSW_MODE_NORMAL}, '{24'hFD0000, 16'h0000, DSW_MODE_PD1K},
        '{24'h22FFFF, 16'hFFFF, DSW_MODE_PD100K}, '{24'h375AA5, 16'h5AA5, DSW_MODE_PDTRI},
        '{24'h000001, 16'h0001, DSW_MODE_NORMAL}};
    always #25 clk = ~clk;
    always @(posedge clk) nDone <= nDone + int'(wordDone === 1'b1);
    dsw_host_model host_u (.serClk(serClk), .frameSelN(frameSelN), .serData(serData));
    dsw_serial_port dut_u (.clk(clk), .rstn(rstn), .ce(1'b1), .serClk(serClk), .frameSelN(frameSelN),
        .serData(serData), .dacCode(dacCode), .powerMode(powerMode), .wordDone(wordDone), .fifoFull(fifoFull));
    task automatic wrapUp;
        $display("Checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic frame(input logic [23:0] w, input int n, input logic [15:0] c, input dsw_mode_type m, int d);
        base = nDone;
        host_u.send(w, n);
        @(negedge clk);
        `CHK("dacCode", c, dacCode)
        `CHK("powerMode", m, powerMode)
        `CHK("updates", d, nDone - base)
        `CHK("fifoFull", 1'b0, fifoFull)
        $display("Test done %h", w);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        `CHK("resetCode", `DSW_MIDSCALE, dacCode)
        `CHK("resetMode", DSW_MODE_NORMAL, powerMode)
        $display("Test done start reset");
        foreach (rows[i]) frame(rows[i].w, 24, rows[i].c, rows[i].m, 1);
        frame(24'h00FFFF, 23, 16'h0001, DSW_MODE_NORMAL, 0);
        frame(24'h111357, 24, 16'h1357, DSW_MODE_PD1K, 1);
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        `CHK("reReset", `DSW_MIDSCALE, dacCode)
        `CHK("reResetMode", DSW_MODE_NORMAL, powerMode)
        rstn = 1'b1;
        $display("Test done reset");
        frame(24'h375AA5, 24, 16'h5AA5, DSW_MODE_PDTRI, 1);
        wrapUp;
    end
    initial begin
        #50000;
        errTotal++;
        wrapUp;
    end
endmodule
`default_nettype wire
